/* hdl/ltdg_defines.svh */
// constants for the lin transmit dominant guard
// assumes inclusion by bare name from the design file
`ifndef LTDG_DEFINES_SVH
`define LTDG_DEFINES_SVH
`define LTDG_ADDR_W             8
`define LTDG_OFS_CTRL           8'h1D
`define LTDG_OFS_STATUS         8'h5A
`define LTDG_OFS_MASK           8'h5B
`define LTDG_OFS_STATE          8'h5C
`define LTDG_CTRL_DTO_DIS_BIT   5
`define LTDG_CTRL_FAST_BIT      0
`define LTDG_ST_DTO_BIT         6
`define LTDG_ST_WAKE_BIT        7
`define LTDG_CTRL_RST           8'h00
`define LTDG_MASK_RST           8'h00
`define LTDG_CLK_HZ             50000000
`define LTDG_DTO_US             50000
`define LTDG_DTO_CYC            ((`LTDG_DTO_US * (`LTDG_CLK_HZ / 1000000)))
`endif

/* hdl/ltdg_pkg.sv */
// types for the lin transmit dominant guard
// assumes the defines header sits beside it
package ltdg_pkg;
	typedef enum logic [1:0] {
		LTDG_MODE_NORMAL,
		LTDG_MODE_SLEEP,
		LTDG_MODE_STANDBY
	} ltdg_mode_t;
	typedef enum logic [1:0] {
		LTDG_SLP_IDLE,
		LTDG_SLP_LOCKED,
		LTDG_SLP_ARMED
	} ltdg_slp_t;
endpackage : ltdg_pkg

/* hdl/ltdg_top.sv */
// lin transmit dominant-timeout guard and false-wake lockout
// assumes transmit, bus level and mode inputs synchronous to ref_clk_i
// Notes on behaviour
// [RULE1] in normal mode each transmit falling edge starts the dominant timer.
// [RULE2] transmit held low past the timeout disables the bus driver; a low begun outside normal mode is not timed, so the driver stays on.
// [RULE3] a transmit rising edge clears the fault and resets the timer.
// [RULE4] during the fault mode, receive echo and pull-up stay unchanged.
// [RULE5] control bit 5 at 0x1D set to one disables the timeout.
// [RULE6] each sleep entry samples the bus level before arming wake.
// [RULE7] bus dominant at sleep entry locks wake until recessive is seen.
// [RULE8] thermal shutdown keeps the bus driver off whatever transmit does.
// [RULE9] fast mode passes transmit and receive at up to 200 kbps.
// [RULE10] receive path is unfiltered so rates above 100 kbps pass.
// [RULE11] unconnected transmit input is taken as high, driver recessive.
// [RULE12] floating bus pin is taken as recessive on the receive output.
// [RULE13] a dominant timeout sets a write-one-to-clear interrupt flag.
// [RULE14] timeout is a clock counter compared to a parameterised threshold.
//
// Design decisions made here: the plain strobed port and the address map.
`include "ltdg_defines.svh"
module ltdg_top
	import ltdg_pkg::*;
#(
	parameter int unsigned DTO_CYCLES = `LTDG_DTO_CYC,
	parameter int unsigned CNT_W      = 22
) (
	// clock and reset
	input  wire logic                    ref_clk_i,
	input  wire logic                    rstn_i,
	// host side
	input  wire logic                    txd_i,
	input  wire logic                    txd_conn_i,
	output logic                         rxd_o,
	input  wire logic [1:0]              mode_req_i,
	input  wire logic                    thermal_shutdown_i,
	// bus side
	input  wire logic                    bus_i,
	input  wire logic                    bus_conn_i,
	output logic                         bus_o,
	output logic                         bus_oe_o,
	output logic                         pullup_en_o,
	output logic                         wake_o,
	output logic [1:0]                   mode_o,
	// register port
	input  wire logic [`LTDG_ADDR_W-1:0] reg_addr_i,
	input  wire logic [7:0]              reg_wdata_i,
	input  wire logic                    reg_wr_i,
	input  wire logic                    reg_rd_i,
	output logic [7:0]                   reg_rdata_o,
	// interrupt
	output logic                         irq_o
);
	typedef struct packed {
		ltdg_mode_t       mode;
		ltdg_slp_t        slp;
		logic             txd_q;
		logic [CNT_W-1:0] cnt;
		logic             timing;
		logic             fault;
		logic [7:0]       ctrl;
		logic [7:0]       status;
		logic [7:0]       mask;
		logic [7:0]       rdata;
		logic             rxd;
		logic             drive;
		logic             wake;
	} ltdg_state_t;

	localparam logic [CNT_W-1:0] THRESH = CNT_W'(DTO_CYCLES);

	ltdg_state_t st_r;
	ltdg_state_t st_nxt;
	logic        txd_eff;
	logic        bus_eff;
	logic        fall;
	logic        rise;
	logic        dto_ev;
	logic        wake_ev;
	ltdg_mode_t  req_mode;

	assign txd_eff = txd_conn_i ? txd_i : 1'b1; // [RULE11]
	assign bus_eff = bus_conn_i ? bus_i : 1'b1; // [RULE12]
	assign fall    = st_r.txd_q & ~txd_eff;
	assign rise    = ~st_r.txd_q & txd_eff;

	always_comb begin
		case (mode_req_i)
			2'd1:    req_mode = LTDG_MODE_SLEEP;
			2'd2:    req_mode = LTDG_MODE_STANDBY;
			default: req_mode = LTDG_MODE_NORMAL;
		endcase
	end

	always_comb begin
		st_nxt       = st_r;
		dto_ev       = 1'b0;
		wake_ev      = 1'b0;
		st_nxt.txd_q = txd_eff;
		st_nxt.mode  = req_mode; // [RULE4]
		// dominant timer
		if (rise) begin
			st_nxt.timing = 1'b0; // [RULE3]
			st_nxt.fault  = 1'b0;
			st_nxt.cnt    = '0;
		end else if (fall && st_r.mode == LTDG_MODE_NORMAL) begin
			st_nxt.timing = 1'b1; // [RULE1]
			st_nxt.cnt    = '0;
		end else if (st_r.timing && !st_r.fault) begin
			if (st_r.ctrl[`LTDG_CTRL_DTO_DIS_BIT]) begin
				st_nxt.cnt = '0; // [RULE5]
			end else if (st_r.cnt >= THRESH - 1'b1) begin
				st_nxt.fault = 1'b1; // [RULE2] [RULE14]
				dto_ev       = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + 1'b1; // [RULE14]
			end
		end
		if (st_r.ctrl[`LTDG_CTRL_DTO_DIS_BIT]) begin
			st_nxt.fault = 1'b0; // [RULE5]
		end
		// sleep wake lockout
		st_nxt.wake = 1'b0;
		if (st_r.mode != LTDG_MODE_SLEEP && req_mode == LTDG_MODE_SLEEP) begin
			st_nxt.slp = bus_eff ? LTDG_SLP_ARMED : LTDG_SLP_LOCKED; // [RULE6]
		end else if (req_mode != LTDG_MODE_SLEEP) begin
			st_nxt.slp = LTDG_SLP_IDLE;
		end else begin
			case (st_r.slp)
				LTDG_SLP_LOCKED: if (bus_eff) st_nxt.slp = LTDG_SLP_ARMED; // [RULE7]
				LTDG_SLP_ARMED: begin
					if (!bus_eff) begin
						st_nxt.wake = 1'b1; // [RULE7]
						wake_ev     = 1'b1;
						st_nxt.slp  = LTDG_SLP_IDLE;
					end
				end
				default: st_nxt.slp = st_r.slp;
			endcase
		end
		// receive echoes bus through a register one cycle later, no filter
		st_nxt.rxd   = bus_eff; // [RULE4] [RULE9] [RULE10]
		// driver: dominant only in normal mode without fault or thermal event
		st_nxt.drive = (req_mode == LTDG_MODE_NORMAL) && !txd_eff && !st_nxt.fault
			&& !thermal_shutdown_i; // [RULE2] [RULE8] [RULE9]
		// registers
		st_nxt.rdata = 8'h00;
		if (reg_wr_i) begin
			case (reg_addr_i)
				`LTDG_OFS_CTRL:   st_nxt.ctrl = reg_wdata_i;
				`LTDG_OFS_STATUS: st_nxt.status = st_r.status & ~reg_wdata_i;
				`LTDG_OFS_MASK:   st_nxt.mask = reg_wdata_i;
				default:          st_nxt.ctrl = st_r.ctrl;
			endcase
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				`LTDG_OFS_CTRL:   st_nxt.rdata = st_r.ctrl;
				`LTDG_OFS_STATUS: st_nxt.rdata = st_r.status;
				`LTDG_OFS_MASK:   st_nxt.rdata = st_r.mask;
				`LTDG_OFS_STATE:  st_nxt.rdata = {4'h0, st_r.slp, st_r.fault, st_r.timing};
				default:          st_nxt.rdata = 8'h00;
			endcase
		end
		if (dto_ev) st_nxt.status[`LTDG_ST_DTO_BIT] = 1'b1; // [RULE13]
		if (wake_ev) st_nxt.status[`LTDG_ST_WAKE_BIT] = 1'b1;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r        <= '0;
			st_r.mode   <= LTDG_MODE_NORMAL;
			st_r.slp    <= LTDG_SLP_IDLE;
			st_r.txd_q  <= 1'b1;
			st_r.rxd    <= 1'b1;
			st_r.ctrl   <= `LTDG_CTRL_RST;
			st_r.mask   <= `LTDG_MASK_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rxd_o       = st_r.rxd;
	assign bus_o       = 1'b0;
	assign bus_oe_o    = st_r.drive;
	assign pullup_en_o = 1'b1; // [RULE4]
	assign wake_o      = st_r.wake;
	assign mode_o      = st_r.mode;
	assign reg_rdata_o = st_r.rdata;
	assign irq_o       = |(st_r.status & st_r.mask);
endmodule // ltdg_top

/* test/ltdg_bus_model.sv */
// lin wire: open drain with pull-up, plus a stuck-dominant short
// assumes the guard pulls the wire low while its enable is high
module ltdg_bus_model (
	input  wire logic drv_i,
	input  wire logic stuck_i,
	output logic      bus_o
);
	assign bus_o = !(drv_i || stuck_i); // released wire floats recessive
endmodule // ltdg_bus_model

/* test/ltdg_top_props.sv */
// assertions for the dominant guard, bound into ltdg_top
// assumes one clock domain
module ltdg_top_chk #(parameter int unsigned DTO_CYCLES = 20) (
	input wire logic       ref_clk_i, rstn_i, txd_i, txd_conn_i, rxd_o, thermal_shutdown_i, bus_i,
	input wire logic       bus_conn_i, bus_oe_o, pullup_en_o, wake_o, reg_wr_i, bus_o,
	input wire logic [1:0] mode_req_i, mode_o,
	input wire logic [7:0] reg_addr_i, reg_wdata_i
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	logic        dis_r;
	logic [31:0] hi_r;
	always_ff @(posedge ref_clk_i or negedge rstn_i)
		if (!rstn_i) begin
			dis_r <= 1'b0;
			hi_r  <= '0;
		end else begin
			if (reg_wr_i && reg_addr_i == 8'h1D) dis_r <= reg_wdata_i[5];
			hi_r <= (bus_oe_o && !dis_r) ? hi_r + 1 : '0;
		end
	dom_limit_a: assert property (
		hi_r <= DTO_CYCLES + 1) else $error("driver on past timeout");
	thermal_off_a: assert property (
		thermal_shutdown_i |=> !bus_oe_o) else $error("driver on in thermal shutdown");
	open_txd_a: assert property (
		!txd_conn_i |=> !bus_oe_o) else $error("driver on with txd open");
	rxd_echo_a: assert property (
		bus_conn_i |=> rxd_o == $past(bus_i)) else $error("rxd not following bus");
	float_bus_a: assert property (
		!bus_conn_i |=> rxd_o) else $error("floating bus not recessive");
	drive_low_a: assert property (
		bus_oe_o |-> !bus_o) else $error("driver enabled but not pulling low");
	pullup_on_a: assert property (
		pullup_en_o) else $error("pull-up off");
	wake_cause_a: assert property (
		wake_o |-> !$past(bus_i) || !$past(bus_i, 2)) else $error("wake without dominant");
	fall_drive_a: assert property (
		mode_o == 2'd0 && mode_req_i == 2'd0 && !thermal_shutdown_i && txd_conn_i && $fell(txd_i)
		|=> bus_oe_o) else $error("fall after rise not driven");
	dis_hold_a: assert property (
		dis_r && $past(dis_r) && bus_oe_o && !txd_i && txd_conn_i && !thermal_shutdown_i && mode_req_i == 2'd0
		|=> bus_oe_o) else $error("timeout applied while disabled");
	cover property (wake_o);
	cover property (hi_r == DTO_CYCLES);
	cover property (dis_r && hi_r == DTO_CYCLES + 4);
endmodule // ltdg_top_chk
bind ltdg_top ltdg_top_chk #(.DTO_CYCLES(DTO_CYCLES)) chk_u (.*);

/* test/lin_tx_dominant_guard_tb.sv */
// self-checking bench for the dominant guard
// assumes a short timeout parameter and the bus model beside it
module lin_tx_dominant_guard_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DTO = 20;
	logic       clk = 0, rstn = 0, txd = 1, tconn = 1, th = 0, bconn = 1, stuck = 0, wr = 0, rd = 0, t, c, h;
	logic [1:0] mreq = 0, mode;
	logic [7:0] addr = 0, wdata = 0, rdata;
	logic       rxd, bus, oe, pu, wake, irq;
	int         n_fail = 0, tests_run = 0, n_wake = 0;
	always #10 clk = ~clk;
	always @(posedge clk) if (wake === 1'b1) n_wake++;
	ltdg_top #(.DTO_CYCLES(DTO)) dut_u (.ref_clk_i(clk), .rstn_i(rstn), .txd_i(txd), .txd_conn_i(tconn),
		.rxd_o(rxd), .mode_req_i(mreq), .thermal_shutdown_i(th), .bus_i(bus), .bus_conn_i(bconn), .bus_o(),
		.bus_oe_o(oe), .pullup_en_o(pu), .wake_o(wake), .mode_o(mode), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq));
	ltdg_bus_model bus_u (.drv_i(oe), .stuck_i(stuck), .bus_o(bus));
	function automatic logic exp_oe(input logic t, c, h);
		return c && !t && !h;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wreg(input logic [7:0] a, d);
		@(posedge clk) begin wr <= 1; addr <= a; wdata <= d; end
		@(posedge clk) wr <= 0;
	endtask
	task automatic rreg(input logic [7:0] a, exp);
		@(posedge clk) begin rd <= 1; addr <= a; end
		@(posedge clk) rd <= 0;
		@(negedge clk) chk(rdata, exp);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		cyc(2000);
		n_fail++;
		complete_run;
	end
	initial begin
		void'($urandom(19));
		cyc(3);
		rstn <= 1;
		wreg(8'h5B, 8'h40);
		@(posedge clk) txd <= 0;
		cyc(DTO + 5);
		@(negedge clk) chk(8'(oe), 8'h00);
		chk({rxd, pu, mode}, 8'h0C);
		chk(8'(irq), 8'h01);
		rreg(8'h5A, 8'h40);
		@(posedge clk) txd <= 1;
		wreg(8'h5A, 8'h40);
		cyc(2);
		@(negedge clk) chk(8'(irq), 8'h00);
		@(posedge clk) txd <= 0;
		cyc(2);
		@(negedge clk) chk(8'(oe), 8'h01);
		rreg(8'h00, 8'h00);
		$display("timeout test done");
		@(posedge clk) txd <= 1;
		wreg(8'h1D, 8'h20);
		@(posedge clk) txd <= 0;
		cyc(DTO + 5);
		@(negedge clk) chk(8'(oe), 8'h01);
		@(posedge clk) txd <= 1;
		wreg(8'h1D, 8'h00);
		$display("disable test done");
		repeat (40) begin
			t = ($urandom % 4) != 0;
			c = ($urandom % 8) != 0;
			h = ($urandom % 4) == 0;
			// a recessive cycle first, so each draw with transmit low and connected starts a fresh dominant timer
			@(posedge clk) begin txd <= 1; tconn <= 1; end
			@(posedge clk) begin txd <= t; tconn <= c; th <= h; end
			@(posedge clk);
			@(negedge clk) chk(8'(oe), 8'(exp_oe(t, c, h)));
		end
		$display("random test done");
		@(posedge clk) begin txd <= 1; tconn <= 1; th <= 0; stuck <= 1; mreq <= 2'd1; end
		cyc(10);
		@(negedge clk) chk(8'(n_wake), 8'h00);
		@(posedge clk) stuck <= 0;
		cyc(5);
		@(posedge clk) stuck <= 1;
		cyc(5);
		@(negedge clk) chk(8'(n_wake), 8'h01);
		rreg(8'h5A, 8'h80);
		$display("lockout test done");
		@(posedge clk) begin mreq <= 2'd0; bconn <= 0; end
		cyc(2);
		@(negedge clk) chk(8'(rxd), 8'h01);
		$display("float test done");
		complete_run;
	end
endmodule // lin_tx_dominant_guard_tb
